// file: common/lcd_timing_pkg.sv
package lcd_timing_pkg;

  // ---------------------------------------------------------------
  // register addresses in the processor register file
  // ---------------------------------------------------------------
  localparam logic [8:0] ADDR_IRQ_FLAGS   = 9'h00C;
  localparam logic [8:0] ADDR_IRQ_ENABLE  = 9'h08C;
  localparam logic [8:0] ADDR_SEG_ENABLE  = 9'h10D;
  localparam logic [8:0] ADDR_PRESCALE    = 9'h10E;
  localparam logic [8:0] ADDR_CONTROL     = 9'h10F;
  localparam logic [8:0] ADDR_PIXEL_BASE  = 9'h110;
  localparam int         PIXEL_REGS       = 16;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT  = 7;
  localparam int CTRL_SLEEP_BIT   = 6;
  localparam int CTRL_VGEN_BIT    = 4;
  localparam int CTRL_CS_HI       = 3;
  localparam int CTRL_CS_LO       = 2;
  localparam int CTRL_MUX_HI      = 1;
  localparam int CTRL_MUX_LO      = 0;
  localparam int PRESCALE_HI      = 3;
  localparam int IRQ_FLAG_BIT     = 7;
  localparam int IRQ_ENABLE_BIT   = 7;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [3:0] PRESCALE_RESET   = 4'h0;
  localparam logic [7:0] SEG_ENABLE_RESET = 8'hFF;
  localparam logic [7:0] PIXEL_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // clock sources and divider counts
  // ---------------------------------------------------------------
  localparam logic [1:0] CS_SYSCLK      = 2'h0;
  localparam logic [1:0] CS_SECOND_OSC  = 2'h1;
  localparam int         SYS_DIV        = 256;
  localparam logic [7:0] SYS_DIV_LAST   = 8'(SYS_DIV - 1);
  localparam int         FRAME_DIV_NORM = 128;
  localparam int         FRAME_DIV_3MUX = 96;
  localparam logic [6:0] FRAME_LAST_NORM = 7'(FRAME_DIV_NORM - 1);
  localparam logic [6:0] FRAME_LAST_3MUX = 7'(FRAME_DIV_3MUX - 1);

  typedef enum logic [1:0] {
    MUX_STATIC,
    MUX_HALF,
    MUX_THIRD,
    MUX_QUARTER
  } mux_mode_t;

endpackage

// file: verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a change counts only once two late stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncOut <= 1'b0;
    end else if (stage2_reg == stage3_reg) begin
      syncOut <= stage3_reg;
    end
  end

endmodule

`default_nettype wire

// file: verilog/lcd_segment_timing_controller.sv
// Operation
// - three timing sources: internal RC, second timer oscillator, divided system clock
// - clock source chosen by control register bits 3 to 2
// - system clock path uses a fixed divide by 256
// - RC oscillator powered down when unselected or module disabled
// - one to four common phases set by control bits 1 to 0
// - static, 1/2, 1/4 frame equals clock over 128 times prescale plus one
// - 1/3 frame equals clock over 96 times prescale plus one
// - a frame starts at the leading edge of the first common
// - frame flag set right after last pixel fetch of the frame
// - next frame fetch begins within the fetch delay after the flag
// - each pixel bit drives one pixel, one means dark
// - unused pixel bits stay readable and writable storage
// - control bit 6 chooses stop or keep running in sleep
// - stop in sleep halts at once, all lines at minimum level
// - keep running in sleep shows current pixels on RC or oscillator
// - pixel data cannot change while the processor sleeps
// - segment enable set gives display drive, clear gives digital pin
// - a set segment enable overrides the port direction bits
// - after reset all segment groups are display drivers
// - multiplex select wins over segment enables on three upper pins; pinLcdMode and pinDirEff ignore it, upperCommonPin only marks them
// - prescale value is bits 3 to 0 of the prescale register
// - frame flag is bit 7 of flags, enable bit 7 of enables
// - module runs only while control bit 7 is set
`timescale 1ns/100ps
`default_nettype none

module lcd_segment_timing_controller (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [8:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  output var  logic [7:0] regRdData,
  input  wire logic       cpuSleep,
  input  wire logic       rcClkIn,
  input  wire logic       secOscClkIn,
  input  wire logic       secOscEnable,
  input  wire logic [7:0] portDirBits,
  output logic            rcOscPowerEn,
  output logic [3:0]      comOut,
  output logic [31:0]     segOut,
  output logic [7:0]      pinLcdMode,
  output logic [7:0]      pinDirEff,
  output logic [2:0]      upperCommonPin,
  output logic            voltageGenEn,
  output logic            frameIrqReq
);

  import lcd_timing_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]        control_reg;
  logic [3:0]        prescale_reg;
  logic [7:0]        segEnable_reg;
  logic              irqFlag_reg;
  logic              irqEnable_reg;
  logic [15:0][7:0]  pixelMem;

  logic              wrOk;
  logic              displayEnable;
  logic              stopInSleep;
  logic [1:0]        clockSel;
  mux_mode_t         muxMode;
  logic              running;
  logic              fetchDone;

  assign displayEnable = control_reg[CTRL_ENABLE_BIT];
  assign stopInSleep   = control_reg[CTRL_SLEEP_BIT];
  assign clockSel      = control_reg[CTRL_CS_HI:CTRL_CS_LO];
  assign muxMode       = mux_mode_t'(control_reg[CTRL_MUX_HI:CTRL_MUX_LO]);
  assign voltageGenEn  = control_reg[CTRL_VGEN_BIT];

  // the core issues no writes while asleep
  assign wrOk = regWrEn && !cpuSleep;

  assign running = displayEnable && !(cpuSleep && stopInSleep);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_reg <= CONTROL_RESET;
    end else if (wrOk && regAddr == ADDR_CONTROL) begin
      control_reg <= regWrData & 8'hDF;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale_reg <= PRESCALE_RESET;
    end else if (wrOk && regAddr == ADDR_PRESCALE) begin
      prescale_reg <= regWrData[PRESCALE_HI:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      segEnable_reg <= SEG_ENABLE_RESET;
    end else if (wrOk && regAddr == ADDR_SEG_ENABLE) begin
      segEnable_reg <= regWrData;
    end
  end

  // every pixel bit is plain storage, used or not
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < PIXEL_REGS; i++) begin
        pixelMem[i] <= PIXEL_RESET;
      end
    end else if (wrOk && regAddr[8:4] == ADDR_PIXEL_BASE[8:4]) begin
      pixelMem[regAddr[3:0]] <= regWrData;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqFlag_reg <= 1'b0;
    end else if (fetchDone) begin
      irqFlag_reg <= 1'b1;
    end else if (wrOk && regAddr == ADDR_IRQ_FLAGS) begin
      irqFlag_reg <= regWrData[IRQ_FLAG_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqEnable_reg <= 1'b0;
    end else if (wrOk && regAddr == ADDR_IRQ_ENABLE) begin
      irqEnable_reg <= regWrData[IRQ_ENABLE_BIT];
    end
  end

  assign frameIrqReq = irqFlag_reg && irqEnable_reg;

  // read data follows the address by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regAddr[8:4] == ADDR_PIXEL_BASE[8:4]) begin
      regRdData <= pixelMem[regAddr[3:0]];
    end else begin
      case (regAddr)
        ADDR_CONTROL:    regRdData <= control_reg;
        ADDR_PRESCALE:   regRdData <= {4'h0, prescale_reg};
        ADDR_SEG_ENABLE: regRdData <= segEnable_reg;
        ADDR_IRQ_FLAGS:  regRdData <= {irqFlag_reg, 7'h00};
        ADDR_IRQ_ENABLE: regRdData <= {irqEnable_reg, 7'h00};
        default:         regRdData <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  logic       rcLevel;
  logic       oscLevel;
  logic       rcLevelDly;
  logic       oscLevelDly;
  logic [7:0] sysDiv_reg;
  logic       sysTick;
  logic       srcTick;

  pin_sync rcSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (rcClkIn),
    .syncOut (rcLevel)
  );

  pin_sync oscSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (secOscClkIn),
    .syncOut (oscLevel)
  );

  assign rcOscPowerEn = displayEnable && clockSel[1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcLevelDly  <= 1'b0;
      oscLevelDly <= 1'b0;
    end else begin
      rcLevelDly  <= rcLevel;
      oscLevelDly <= oscLevel;
    end
  end

  // the core clock stops in sleep, so this source stops with it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sysDiv_reg <= 8'h00;
    end else if (!cpuSleep) begin
      sysDiv_reg <= sysDiv_reg + 8'h01;
    end
  end

  assign sysTick = !cpuSleep && sysDiv_reg == SYS_DIV_LAST;

  always_comb begin
    srcTick = 1'b0;
    if (clockSel[1]) begin
      srcTick = rcLevel && !rcLevelDly;
    end else if (clockSel == CS_SECOND_OSC) begin
      srcTick = secOscEnable && oscLevel && !oscLevelDly;
    end else begin
      srcTick = sysTick;
    end
  end

  // ---------------------------------------------------------------
  // frame and common phase timing
  // ---------------------------------------------------------------
  logic [3:0] psCnt_reg;
  logic       subTick;
  logic [6:0] frameCnt_reg;
  logic [6:0] frameCnt_next;
  logic [6:0] frameLast;
  logic [1:0] phaseNext;
  logic [1:0] phaseLast;
  logic       phaseStart;
  logic       enableDly;
  logic       startPulse;
  logic       loadNow;
  logic [31:0] segLatch;
  logic [3:0]  comLatch;

  assign subTick   = running && srcTick && psCnt_reg == prescale_reg;
  assign frameLast = (muxMode == MUX_THIRD) ? FRAME_LAST_3MUX : FRAME_LAST_NORM;

  always_ff @(posedge clk) begin
    if (!rst_n || !displayEnable) begin
      psCnt_reg <= 4'h0;
    end else if (running && srcTick) begin
      psCnt_reg <= subTick ? 4'h0 : psCnt_reg + 4'h1;
    end
  end

  assign frameCnt_next = (frameCnt_reg >= frameLast) ? 7'h00 : frameCnt_reg + 7'h01;

  always_ff @(posedge clk) begin
    if (!rst_n || !displayEnable) begin
      frameCnt_reg <= 7'h00;
    end else if (subTick) begin
      frameCnt_reg <= frameCnt_next;
    end
  end

  // each phase is a fixed slice of the frame count
  always_comb begin
    phaseNext  = 2'h0;
    phaseLast  = 2'h0;
    phaseStart = 1'b0;
    case (muxMode)
      MUX_STATIC: begin
        phaseStart = subTick && frameCnt_next == 7'h00;
      end
      MUX_HALF: begin
        phaseNext  = {1'b0, frameCnt_next[6]};
        phaseLast  = 2'h1;
        phaseStart = subTick && frameCnt_next[5:0] == 6'h00;
      end
      MUX_THIRD: begin
        phaseNext  = frameCnt_next[6:5];
        phaseLast  = 2'h2;
        phaseStart = subTick && frameCnt_next[4:0] == 5'h00;
      end
      MUX_QUARTER: begin
        phaseNext  = frameCnt_next[6:5];
        phaseLast  = 2'h3;
        phaseStart = subTick && frameCnt_next[4:0] == 5'h00;
      end
      default: begin
        phaseStart = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enableDly <= 1'b0;
    end else begin
      enableDly <= displayEnable;
    end
  end

  // at enable the first frame begins with common zero
  assign startPulse = displayEnable && !enableDly;
  assign loadNow    = running && (phaseStart || startPulse);
  assign fetchDone  = running && phaseStart && phaseNext == phaseLast;

  always_ff @(posedge clk) begin
    if (!rst_n || !displayEnable) begin
      segLatch <= 32'h0000_0000;
      comLatch <= 4'h0;
    end else if (loadNow) begin
      if (startPulse) begin
        segLatch <= {pixelMem[3], pixelMem[2], pixelMem[1], pixelMem[0]};
        comLatch <= 4'h1;
      end else begin
        segLatch <= {pixelMem[{phaseNext, 2'h3}], pixelMem[{phaseNext, 2'h2}],
                     pixelMem[{phaseNext, 2'h1}], pixelMem[{phaseNext, 2'h0}]};
        comLatch <= 4'(4'h1 << phaseNext);
      end
    end
  end

  // halted or disabled: every line sits at the lowest level
  always_ff @(posedge clk) begin
    if (!rst_n || !running) begin
      segOut <= 32'h0000_0000;
      comOut <= 4'h0;
    end else begin
      segOut <= segLatch;
      comOut <= comLatch;
    end
  end

  // ---------------------------------------------------------------
  // pin function
  // ---------------------------------------------------------------
  assign pinLcdMode = segEnable_reg;
  assign pinDirEff  = portDirBits & ~segEnable_reg;

  always_comb begin
    case (muxMode)
      MUX_HALF:    upperCommonPin = 3'h4;
      MUX_THIRD:   upperCommonPin = 3'h6;
      MUX_QUARTER: upperCommonPin = 3'h7;
      default:     upperCommonPin = 3'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_sys_divider: assert property (@(posedge clk) disable iff (!rst_n)
    sysTick |=> (!sysTick) [*8])
    else $error("system divider ticked too soon");

  a_halt_blank: assert property (@(posedge clk) disable iff (!rst_n)
    (cpuSleep && stopInSleep) |=> (segOut == 32'h0000_0000 && comOut == 4'h0))
    else $error("lines not at minimum while halted");

  a_sleep_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    cpuSleep |=> $stable(pixelMem))
    else $error("pixel data changed during sleep");

  a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    fetchDone |=> irqFlag_reg ##1 (irqFlag_reg || $past(wrOk)))
    else $error("frame flag not set after fetch");

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (irqFlag_reg && !(wrOk && regAddr == ADDR_IRQ_FLAGS)) |=> (irqFlag_reg && (frameIrqReq == irqEnable_reg)))
    else $error("frame flag dropped without a clear");

  a_rc_power: assert property (@(posedge clk) disable iff (!rst_n)
    (!displayEnable || !clockSel[1]) |-> !rcOscPowerEn)
    else $error("rc oscillator powered while unused");

  a_common_count: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(comOut) and ((loadNow && muxMode == MUX_STATIC) |=> ##1 (comOut == 4'h1 || !$past(running))))
    else $error("common phase outside multiplex mode");

  a_dir_override: assert property (@(posedge clk) disable iff (!rst_n)
    (segEnable_reg == 8'hFF) |-> (pinDirEff == 8'h00 && pinLcdMode == 8'hFF))
    else $error("segment enable did not override direction");

  a_upper_pins: assert property (@(posedge clk) disable iff (!rst_n)
    (muxMode == MUX_QUARTER) |-> upperCommonPin == 3'h7)
    else $error("upper pins not commons in quarter mode");

endmodule

`default_nettype wire

// file: tb/lcd_glass_model.sv
`timescale 1ns/100ps
`default_nettype none

module lcd_glass_model (
  input  wire logic        clk,
  input  wire logic [3:0]  comOut,
  input  wire logic [31:0] segOut,
  output var  logic [31:0] rowSeen [4],
  output var  int          framePeriod,
  output var  int          frameCount
);
  logic [3:0] comPrev;
  int         age;

  initial begin
    comPrev     = 4'h0;
    age         = 0;
    framePeriod = 0;
    frameCount  = 0;
  end

  // a row is only seen while its common drives the glass
  always @(posedge clk) begin
    comPrev <= comOut;
    age     <= age + 1;
    for (int c = 0; c < 4; c++) begin
      if (comOut[c] === 1'b1) rowSeen[c] <= segOut;
    end
    if (comOut[0] === 1'b1 && comPrev[0] !== 1'b1) begin
      framePeriod <= age + 1;
      age         <= 0;
      frameCount  <= frameCount + 1;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  import lcd_timing_pkg::*;
  logic        clk, rst_n, regWrEn, cpuSleep, rcClkIn, secOscClkIn, secOscEnable;
  logic [8:0]  regAddr;
  logic [7:0]  regWrData, portDirBits;
  wire  [7:0]  regRdData, pinLcdMode, pinDirEff;
  wire  [3:0]  comOut;
  wire  [31:0] segOut;
  wire  [2:0]  upperCommonPin;
  wire         rcOscPowerEn, voltageGenEn, frameIrqReq;
  wire  [31:0] rowSeen [4];
  int          framePeriod, frameCount, miscompares, compares, cyc, n, k, fc;
  logic [7:0]  ctrl, se, ien, pix [16];
  logic [3:0]  ps;
  int          tm [3] = '{1, 2, 3};
  int          tp [3] = '{2, 1, 0};
  logic [7:0]  tc [3] = '{8'h8C, 8'h88, 8'h88};

  lcd_segment_timing_controller u_lcd_segment_timing_controller (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdData(regRdData), .cpuSleep(cpuSleep), .rcClkIn(rcClkIn), .secOscClkIn(secOscClkIn),
    .secOscEnable(secOscEnable), .portDirBits(portDirBits), .rcOscPowerEn(rcOscPowerEn),
    .comOut(comOut), .segOut(segOut), .pinLcdMode(pinLcdMode), .pinDirEff(pinDirEff),
    .upperCommonPin(upperCommonPin), .voltageGenEn(voltageGenEn), .frameIrqReq(frameIrqReq));

  lcd_glass_model u_lcd_glass_model (
    .clk(clk), .comOut(comOut), .segOut(segOut), .rowSeen(rowSeen),
    .framePeriod(framePeriod), .frameCount(frameCount));

  // ----------------------------------------
  // clocks and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // oscillators are 6 and 8 clk periods, so frame lengths come out exact
  initial begin
    rcClkIn = 1'b0;
    forever #300 rcClkIn = ~rcClkIn;
  end
  initial begin
    secOscClkIn = 1'b0;
    forever #400 secOscClkIn = ~secOscClkIn;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] expRd(input logic [8:0] a);
    if (a >= ADDR_PIXEL_BASE && a < ADDR_PIXEL_BASE + 9'h010) return pix[a[3:0]];
    case (a)
      ADDR_IRQ_ENABLE: return ien;
      ADDR_SEG_ENABLE: return se;
      ADDR_PRESCALE:   return {4'h0, ps};
      ADDR_CONTROL:    return ctrl;
      default:         return 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    if (cpuSleep !== 1'b1) begin
      if (a >= ADDR_PIXEL_BASE && a < ADDR_PIXEL_BASE + 9'h010) pix[a[3:0]] = d;
      if (a == ADDR_IRQ_ENABLE) ien = d & 8'h80;
      if (a == ADDR_SEG_ENABLE) se = d;
      if (a == ADDR_PRESCALE) ps = d[3:0];
      if (a == ADDR_CONTROL) ctrl = d & 8'hDF;
    end
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    regAddr = a;
    @(posedge clk);
    #1;
    check("regRdData", regRdData, e);
  endtask

  task automatic waitFrames(input int f);
    int start;
    start = frameCount;
    for (k = 0; k < 10000 && frameCount < start + f; k++) @(posedge clk);
    #1;
    check("frames", 32'(frameCount - start >= f), 1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    regAddr = 9'h000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    cpuSleep = 1'b0;
    secOscEnable = 1'b1;
    portDirBits = 8'hFF;
    ctrl = 8'h00;
    se = 8'hFF;
    ien = 8'h00;
    ps = 4'h0;
    foreach (pix[i]) pix[i] = 8'h00;
    n = $urandom(70);
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("pinLcdMode", pinLcdMode, 8'hFF);
    check("pinDirEff", pinDirEff, 8'h00);
    for (int a = 9'h10C; a < 9'h120; a++) rd(9'(a), expRd(9'(a)));
    // storage and field widths with random contents
    for (int i = 0; i < 16; i++) wr(ADDR_PIXEL_BASE + 9'(i), 8'($urandom));
    wr(ADDR_PRESCALE, 8'hFF);
    wr(ADDR_CONTROL, 8'h7F);
    wr(ADDR_SEG_ENABLE, 8'($urandom));
    portDirBits = 8'($urandom);
    for (int a = 9'h10C; a < 9'h120; a++) rd(9'(a), expRd(9'(a)));
    check("rcOscPowerEn", rcOscPowerEn, 0);
    check("voltageGenEn", voltageGenEn, 1);
    check("pinLcdMode", pinLcdMode, se);
    check("pinDirEff", pinDirEff, portDirBits & ~se);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CONTROL, 8'(m));
      check("upperCommonPin", upperCommonPin, {m >= 1, m >= 2, m == 3});
    end
    // frame lengths on the RC source
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_PRESCALE, 8'(tp[i]));
      check("comOut", comOut, 0);
      wr(ADDR_CONTROL, tc[i] | 8'(tm[i]));
      check("rcOscPowerEn", rcOscPowerEn, 1);
      // the frame begun at enable is cut short, so measure a later one
      waitFrames(3);
      check("framePeriod", framePeriod, (tm[i] == 2 ? 96 : 128) * (tp[i] + 1) * 6);
    end
    for (int c = 0; c < 4; c++) check("row", rowSeen[c], {pix[4*c+3], pix[4*c+2], pix[4*c+1], pix[4*c]});
    check("frameIrqReq", frameIrqReq, 0);
    rd(ADDR_IRQ_FLAGS, 8'h80);
    wr(ADDR_IRQ_ENABLE, 8'h80);
    check("frameIrqReq", frameIrqReq, 1);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    check("frameIrqReq", frameIrqReq, 0);
    for (k = 0; k < 2000 && frameIrqReq !== 1'b1; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
    check("comOut", comOut, 4'h8);
    // static drive keeps common zero and row zero up
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h88);
    repeat (2) @(posedge clk);
    #1;
    check("comOut", comOut, 4'h1);
    check("segOut", segOut, {pix[3], pix[2], pix[1], pix[0]});
    // divided system clock: one quarter phase is 32 ticks of 256 clk
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h83);
    check("rcOscPowerEn", rcOscPowerEn, 0);
    for (k = 0; k < 20000 && comOut[1] !== 1'b1; k++) @(posedge clk) #1;
    for (n = 0; n < 20000 && comOut[2] !== 1'b1; n++) @(posedge clk) #1;
    check("phase", n, 8192);
    // second oscillator, then its enable dropped
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h87);
    waitFrames(3);
    check("framePeriod", framePeriod, 1024);
    secOscEnable = 1'b0;
    fc = frameCount;
    repeat (2000) @(posedge clk);
    #1;
    check("frames", frameCount, fc);
    secOscEnable = 1'b1;
    // sleep, keep running, writes ignored
    wr(ADDR_CONTROL, 8'h8B);
    cpuSleep = 1'b1;
    wr(ADDR_PIXEL_BASE, ~pix[0]);
    waitFrames(2);
    cpuSleep = 1'b0;
    rd(ADDR_PIXEL_BASE, expRd(ADDR_PIXEL_BASE));
    // sleep, stop at once
    wr(ADDR_CONTROL, 8'hCB);
    // sleep only just after a frame boundary
    fc = frameCount;
    for (k = 0; k < 2000 && frameCount == fc; k++) @(posedge clk);
    #1;
    cpuSleep = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("comOut", comOut, 0);
    check("segOut", segOut, 0);
    fc = frameCount;
    repeat (1000) @(posedge clk);
    #1;
    check("frames", frameCount, fc);
    cpuSleep = 1'b0;
    print_verdict();
  end
endmodule
`default_nettype wire
